//--- gated_shifter.sv
// Eight-stage gated serial-in, parallel-out shift register
//
// What this block does
// - Eight chained bits, each shown in parallel
// - Either gate low loads low into first
// - Both gates high load high into first
// - Each later stage takes its predecessor each edge
// - Stages shift only on rising clock edge
// - Gate inputs sampled only at the edge
// - Low clear zeroes all stages immediately, overriding
`timescale 1ns/1ps
module gated_shifter
  import shifter_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clear_n,
  input wire serial_in_s i_serial,
  output stage_vec_t o_stages,
  output logic o_stage_one_out,
  output logic o_stage_eight_out
);
  stage_vec_t stages;
  stage_vec_t stage_d;
  wire logic serial_bit;
  wire logic shift_allowed;
  wire logic fill_full;
  logic [3:0] fill_cnt_r;
  logic [3:0] fill_cnt_nxt;

  // Bit offered to the first stage; the checks below share it
  function automatic logic entry_bit(input serial_in_s gates);
    return gates.gate_a & gates.gate_b;
  endfunction : entry_bit

  // One gate low forces a zero; one gate high passes the other through
  assign serial_bit = entry_bit(i_serial);

  // Stage inputs: first from the gated serial bit, the rest from the stage before
  assign stage_d = {stages[LAST_STAGE-1:FIRST_STAGE], serial_bit};

  genvar g;
  generate
    for (g = 0; g < STAGE_COUNT; g++) begin : g_stage
      stage_bit u_stage (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_clear_n(i_clear_n),
        .i_d(stage_d[g]),
        .o_q(stages[g])
      );
    end
  endgenerate

  // Outputs are the stage flip-flops themselves, no further logic
  assign o_stages = stages;
  assign o_stage_one_out = stages[FIRST_STAGE];
  assign o_stage_eight_out = stages[LAST_STAGE];

  chk_first_low: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && !(i_serial.gate_a && i_serial.gate_b)) ##1 i_clear_n
      |-> !o_stage_one_out)
    else $error("first stage not low after a low gate input");

  chk_first_high: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && i_serial.gate_a && i_serial.gate_b) ##1 i_clear_n
      |-> o_stage_one_out)
    else $error("first stage not high after both gates high");

  chk_shift_chain: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_clear_n ##1 i_clear_n
      |-> o_stages[LAST_STAGE:1] == $past(o_stages[LAST_STAGE-1:FIRST_STAGE]))
    else $error("stages did not shift by one place");

  chk_sample_edge: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_clear_n ##1 i_clear_n
      |-> o_stages[FIRST_STAGE] == $past(entry_bit(i_serial)))
    else $error("first stage does not match gates sampled at the edge");

  chk_clear_all: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n |-> o_stages == CLEARED_STAGES)
    else $error("stages not cleared while clear is low");

  chk_clear_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (!i_clear_n && i_serial.gate_a && i_serial.gate_b) [*3]
      |-> o_stages == CLEARED_STAGES && !o_stage_eight_out)
    else $error("clear did not override shifting");

  chk_fill_ones: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && i_serial.gate_a && i_serial.gate_b) [*8] ##1 i_clear_n
      |-> o_stages == ALL_ONES_STAGES && o_stage_eight_out)
    else $error("eight high entries did not fill all stages");

  chk_flush_zeros: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && !i_serial.gate_b) [*8] ##1 i_clear_n
      |-> o_stages == CLEARED_STAGES)
    else $error("eight low entries did not empty all stages");

  // Entry-bit checks
  chk_gate_a_block: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && !i_serial.gate_a && i_serial.gate_b) ##1 i_clear_n
      |-> !o_stage_one_out)
    else $error("low gate a did not block the entry");

  chk_gate_b_block: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && i_serial.gate_a && !i_serial.gate_b) ##1 i_clear_n
      |-> !o_stage_one_out)
    else $error("low gate b did not block the entry");

  chk_gate_a_pass: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && i_serial.gate_a) ##1 i_clear_n
      |-> o_stage_one_out == $past(i_serial.gate_b))
    else $error("high gate a did not let gate b decide");

  chk_gate_b_pass: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && i_serial.gate_b) ##1 i_clear_n
      |-> o_stage_one_out == $past(i_serial.gate_a))
    else $error("high gate b did not let gate a decide");

  // Shift-chain checks
  for (genvar k = 1; k < STAGE_COUNT; k++) begin : g_step_chk
    chk_stage_step: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_clear_n ##1 i_clear_n |-> o_stages[k] == $past(o_stages[k-1]))
      else $error("a stage did not take the value of the one before");
  end

  chk_last_tap: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_clear_n ##1 i_clear_n
      |-> o_stage_eight_out == $past(o_stages[LAST_STAGE-1]))
    else $error("last stage output did not take the seventh stage");

  chk_two_step: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_clear_n ##1 i_clear_n ##1 i_clear_n
      |-> o_stages[LAST_STAGE:2] == $past(o_stages[LAST_STAGE-2:FIRST_STAGE], 2))
    else $error("two edges did not move the stages by two places");

  chk_half_high: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && entry_bit(i_serial)) ##1 i_clear_n [*4]
      |-> o_stages[STAGE_COUNT/2-1])
    else $error("a high entry did not reach the middle of the chain");

  chk_half_low: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && !entry_bit(i_serial)) ##1 i_clear_n [*4]
      |-> !o_stages[STAGE_COUNT/2-1])
    else $error("a low entry did not reach the middle of the chain");

  chk_travel_high: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && entry_bit(i_serial)) ##1 i_clear_n [*8]
      |-> o_stage_eight_out)
    else $error("a high entry did not reach the last stage");

  chk_travel_low: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clear_n && !entry_bit(i_serial)) ##1 i_clear_n [*8]
      |-> !o_stage_eight_out)
    else $error("a low entry did not reach the last stage");

  // Shift edges since the last clear or reset, saturating at a full chain;
  // no stage at or beyond this count can yet hold anything but a low level
  assign shift_allowed = i_reset_n && i_clear_n;
  assign fill_full = fill_cnt_r == 4'(STAGE_COUNT);
  assign fill_cnt_nxt = !shift_allowed ? 4'h0 : fill_full ? fill_cnt_r : fill_cnt_r + 4'h1;

  always_ff @(posedge i_core_clk) begin
    fill_cnt_r <= fill_cnt_nxt;
  end

  chk_clear_extent: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (o_stages >> fill_cnt_r) == CLEARED_STAGES)
    else $error("data reached a stage sooner than shifting allows");

  // Clear checks
  for (genvar k = 0; k < STAGE_COUNT; k++) begin : g_clear_chk
    chk_stage_cleared: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !i_clear_n |-> !o_stages[k])
      else $error("a stage was not low while clear is low");
  end

  chk_clear_taps: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n |-> !o_stage_one_out && !o_stage_eight_out)
    else $error("a stage output was not low while clear is low");

  chk_clear_steady: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n ##1 !i_clear_n
      |-> $stable(o_stages) && o_stages == CLEARED_STAGES)
    else $error("stages moved while clear stayed low");

  chk_release_shift: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n ##1 i_clear_n ##1 i_clear_n
      |-> (o_stages >> 1) == CLEARED_STAGES)
    else $error("first edge after clear moved more than the entry bit");

  chk_entry_after_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n ##1 (i_clear_n && entry_bit(i_serial)) ##1 i_clear_n
      |-> o_stage_one_out && (o_stages >> 1) == CLEARED_STAGES)
    else $error("a high entry after clear was not alone in the first stage");

  chk_low_after_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clear_n ##1 (i_clear_n && !entry_bit(i_serial)) ##1 i_clear_n
      |-> o_stages == CLEARED_STAGES)
    else $error("a low entry after clear left a stage high");
endmodule : gated_shifter

//--- shifter_pkg.sv
// Package with shared types and constants for the gated serial shifter
package shifter_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int FIRST_STAGE = 0;
  localparam int LAST_STAGE = STAGE_COUNT - 1;
  localparam logic STAGE_RESET_VALUE = 1'b0;
  localparam logic [STAGE_COUNT-1:0] CLEARED_STAGES = 8'h00;
  localparam logic [STAGE_COUNT-1:0] ALL_ONES_STAGES = 8'hFF;

  typedef logic [STAGE_COUNT-1:0] stage_vec_t;

  typedef struct packed {
    logic gate_a;
    logic gate_b;
  } serial_in_s;
endpackage : shifter_pkg

//--- stage_bit.sv
// One storage stage: edge-triggered bit with asynchronous clear
`timescale 1ns/1ps
module stage_bit
  import shifter_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clear_n,
  input wire logic i_d,
  output logic o_q
);
  logic q_r;
  logic q_nxt;

  // Synchronous reset folds into the next value; clear acts without the clock
  assign q_nxt = i_reset_n ? i_d : STAGE_RESET_VALUE;

  always_ff @(posedge i_core_clk or negedge i_clear_n) begin
    if (!i_clear_n) begin
      q_r <= STAGE_RESET_VALUE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule : stage_bit

//--- drive_logic.sv
// Far-side driving logic: presents clear and gate levels
`timescale 1ns/1ps
module drive_logic
  import shifter_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [2:0] i_req,
  output serial_in_s o_serial,
  output logic o_clear_n
);
  // Levels move only at falling edges, well clear of setup and hold
  always @(negedge i_core_clk) {o_clear_n, o_serial} <= i_req;
endmodule : drive_logic

//--- test_gated_shifter.sv
// Self-checking testbench for the gated shifter
`timescale 1ns/1ps
module test_gated_shifter;
  import shifter_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [2:0] req = 3'h4;
  serial_in_s gates;
  logic clear_n, one_out, eight_out;
  stage_vec_t stages;
  stage_vec_t exp = CLEARED_STAGES;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (++cycles > 100) begin
    error_cnt++;
    finish_test();
  end
  drive_logic u_drive (.i_core_clk(i_core_clk), .i_req(req), .o_serial(gates),
    .o_clear_n(clear_n));
  gated_shifter dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clear_n(clear_n),
    .i_serial(gates), .o_stages(stages), .o_stage_one_out(one_out),
    .o_stage_eight_out(eight_out));
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask : check
  // Just after the levels change at the falling edge, then just after the rising edge
  task automatic step(input logic [2:0] r);
    req = r;
    if (!r[2]) exp = CLEARED_STAGES;
    @(negedge i_core_clk);
    #1 check({eight_out, one_out, stages}, {exp[7], exp[0], exp});
    @(posedge i_core_clk);
    if (r[2]) exp = {exp[6:0], r[1] & r[0]};
    #1 check({eight_out, one_out, stages}, {exp[7], exp[0], exp});
  endtask : step
  task automatic test_shift();
    for (int i = 0; i < 12; i++) step({1'b1, i[1:0]});
    $display("shift test done");
  endtask : test_shift
  task automatic test_fill();
    repeat (9) step(3'h7);
    check({eight_out, one_out, stages}, {1'b1, 1'b1, ALL_ONES_STAGES});
    $display("fill test done");
  endtask : test_fill
  task automatic test_flush();
    repeat (9) step(3'h6);
    check({eight_out, one_out, stages}, {1'b0, 1'b0, CLEARED_STAGES});
    $display("flush test done");
  endtask : test_flush
  task automatic test_clear();
    step(3'h7);
    repeat (3) step(3'h3);
    step(3'h7);
    step(3'h7);
    step(3'h3);
    step(3'h5);
    step(3'h7);
    $display("clear test done");
  endtask : test_clear
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    @(posedge i_core_clk);
    #1 check({eight_out, one_out, stages}, 10'h000);
    test_shift();
    test_fill();
    test_flush();
    test_clear();
    finish_test();
  end
endmodule : test_gated_shifter
